// ===== core/ssa_fifo.sv
// Result FIFO between the converter core and the output registers
`timescale 1ns/1ps
module ssa_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 32
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0] wr_ptr_ff;
   logic [AW:0] rd_ptr_ff;
   logic push;
   logic pop;

   // Extra pointer bit tells full from empty
   assign in_ready = (wr_ptr_ff ^ rd_ptr_ff) != {1'b1, {AW{1'b0}}};
   assign out_valid = wr_ptr_ff != rd_ptr_ff;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem_ff[rd_ptr_ff[AW-1:0]];

   always_ff @(posedge clk_sys) begin
      if (clk_en && push) begin
         mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end else if (clk_en) begin
         if (flush) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
         end else begin
            if (push) begin
               wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
               rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
         end
      end
   end
endmodule

// ===== core/ssa_host_port.sv
// Control and readout port of the eight-channel sampling converter
`timescale 1ns/1ps

// What this block does
// - Low select parallel, high select serial
// - Serial: strobe is clock, bits 7/8 out
// - Power-down mode chosen by range level
// - Standby keeps references; shutdown powers all down
// - Range high wide, low narrow, immediate
// - Start A: ch1-4, B: ch5-8
// - Start rising edge puts group in hold
// - Reset on rising edge of reset pulse
// - Reset aborts conversion in progress
// - Reset clears output result registers
// - Parallel bus driven only with select+strobe low
// - Two strobes: bits 17:2 then 1:0
// - Select fall enables serial outputs, MSB out
// - Serial clock rise shifts next bit
// - Busy after both starts; ignore starts while busy
// - First flag high at select fall, low 18th fall
module ssa_host_port
   import ssa_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic [OS_W-1:0] oversample_ratio_sel,
   input wire logic interface_select,
   input wire logic power_down_request,
   input wire logic range_select,
   input wire logic convert_start_group_a,
   input wire logic convert_start_group_b,
   input wire logic device_reset,
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   output logic [BUS_W-1:0] parallel_result_bus_o,
   output logic [BUS_W-1:0] parallel_result_bus_oe,
   output logic first_channel_flag,
   output logic first_channel_flag_oe,
   output logic busy,
   output logic hold_group_a,
   output logic hold_group_b,
   output logic conv_start,
   output logic conv_abort,
   output logic [OS_W-1:0] oversample_ratio,
   output logic input_range_wide,
   output logic standby_mode,
   output logic shutdown_mode,
   input wire logic result_valid,
   output logic result_ready,
   input wire logic [RES_W-1:0] result_data
);
   // ==========================================================
   // Pin synchronisers and edge detection
   logic [OS_W-1:0] os_s;
   logic ser_mode_s;
   logic pd_s;
   logic range_s;
   logic cva_s;
   logic cvb_s;
   logic drst_s;
   logic cs_n_s;
   logic rd_n_s;
   logic cva_d_ff;
   logic cvb_d_ff;
   logic drst_d_ff;
   logic cs_n_d_ff;
   logic rd_n_d_ff;

   ssa_sync #(
      .W(OS_W + 6)
   ) u_sync_hi (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .clk_en(clk_en),
      .async_in({oversample_ratio_sel, interface_select, power_down_request, range_select,
                 convert_start_group_a, convert_start_group_b, device_reset}),
      .sync_out({os_s, ser_mode_s, pd_s, range_s, cva_s, cvb_s, drst_s})
   );

   // Idle-high strobes reset high so release makes no false edge
   ssa_sync #(
      .W(2),
      .RST_VAL(2'h3)
   ) u_sync_lo (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .clk_en(clk_en),
      .async_in({chip_select_n, read_strobe_n}),
      .sync_out({cs_n_s, rd_n_s})
   );

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cva_d_ff <= 1'b0;
         cvb_d_ff <= 1'b0;
         drst_d_ff <= 1'b0;
         cs_n_d_ff <= 1'b1;
         rd_n_d_ff <= 1'b1;
      end else if (clk_en) begin
         cva_d_ff <= cva_s;
         cvb_d_ff <= cvb_s;
         drst_d_ff <= drst_s;
         cs_n_d_ff <= cs_n_s;
         rd_n_d_ff <= rd_n_s;
      end
   end

   logic cva_rise;
   logic cvb_rise;
   logic drst_rise;
   logic cs_fall;
   logic rd_fall;
   logic rd_rise;
   logic os_on;
   logic start_a;
   logic start_b;

   assign drst_rise = drst_s & ~drst_d_ff;
   assign cva_rise = cva_s & ~cva_d_ff;
   assign cvb_rise = cvb_s & ~cvb_d_ff;
   assign cs_fall = cs_n_d_ff & ~cs_n_s;
   assign rd_fall = rd_n_d_ff & ~rd_n_s;
   assign rd_rise = ~rd_n_d_ff & rd_n_s;
   assign os_on = os_s != OS_OFF;
   assign start_a = cva_rise | (os_on & cvb_rise);
   assign start_b = cvb_rise | (os_on & cva_rise);

   // ==========================================================
   // Conversion sequencer
   ssa_state_t state_ff;
   logic hold_a_ff;
   logic hold_b_ff;
   logic conv_start_ff;
   logic conv_abort_ff;
   logic [CH_W:0] load_cnt_ff;
   logic go;
   logic load_done;
   logic drain_ready;
   logic drain_valid;
   logic [RES_W-1:0] drain_data;
   logic [RES_W-1:0] res_ff [NUM_CH];

   // both groups held starts one busy period
   assign go = (state_ff != ST_CONV) & ~pd_s & ~drst_rise
               & (hold_a_ff | start_a) & (hold_b_ff | start_b);
   assign load_done = (state_ff == ST_CONV) & (load_cnt_ff == LOAD_DONE);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_ff <= ST_IDLE;
      end else if (clk_en) begin
         if (drst_rise) begin
            state_ff <= ST_IDLE;
         end else begin
            case (state_ff)
               ST_IDLE: begin
                  if (go) begin
                     state_ff <= ST_CONV;
                  end else if (~pd_s & (start_a | start_b)) begin
                     state_ff <= ST_ARM;
                  end
               end
               ST_ARM: begin
                  if (go) begin
                     state_ff <= ST_CONV;
                  end
               end
               ST_CONV: begin
                  if (load_done) begin
                     state_ff <= ST_IDLE;
                  end
               end
               default: begin
                  state_ff <= ST_IDLE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         hold_a_ff <= 1'b0;
         hold_b_ff <= 1'b0;
      end else if (clk_en) begin
         if (drst_rise || load_done) begin
            hold_a_ff <= 1'b0;
            hold_b_ff <= 1'b0;
         end else if (state_ff != ST_CONV && !pd_s) begin
            if (start_a) begin
               hold_a_ff <= 1'b1;
            end
            if (start_b) begin
               hold_b_ff <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         conv_start_ff <= 1'b0;
         conv_abort_ff <= 1'b0;
      end else if (clk_en) begin
         conv_start_ff <= go;
         // core told to drop the conversion
         conv_abort_ff <= drst_rise & (state_ff == ST_CONV);
      end
   end

   // ==========================================================
   // Result buffer and output registers
   // Drain stalls during a host frame so results never change mid-read
   assign drain_ready = (state_ff == ST_CONV) & cs_n_s & (load_cnt_ff != LOAD_DONE);

   ssa_fifo #(
      .WIDTH(RES_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .clk_en(clk_en),
      .flush(drst_rise),
      .in_valid(result_valid),
      .in_ready(result_ready),
      .in_data(result_data),
      .out_valid(drain_valid),
      .out_ready(drain_ready),
      .out_data(drain_data)
   );

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         load_cnt_ff <= '0;
      end else if (clk_en) begin
         if (drst_rise || go) begin
            load_cnt_ff <= '0;
         end else if (drain_valid && drain_ready) begin
            load_cnt_ff <= load_cnt_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_CH; i++) begin
            res_ff[i] <= '0;
         end
      end else if (clk_en) begin
         if (drst_rise) begin
            for (int i = 0; i < NUM_CH; i++) begin
               res_ff[i] <= '0;
            end
         end else if (drain_valid && drain_ready) begin
            res_ff[load_cnt_ff[CH_W-1:0]] <= drain_data;
         end
      end
   end

   // ==========================================================
   // Parallel read path
   logic [CH_W-1:0] par_ch_ff;
   logic par_half_ff;
   logic [BUS_W-1:0] bus_ff;
   logic par_read;

   assign par_read = ~ser_mode_s & ~cs_n_s & rd_fall;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         par_ch_ff <= FIRST_CH;
         par_half_ff <= 1'b0;
         bus_ff <= '0;
      end else if (clk_en) begin
         if (drst_rise || load_done) begin
            par_ch_ff <= FIRST_CH;
            par_half_ff <= 1'b0;
            bus_ff <= '0;
         end else if (par_read) begin
            if (!par_half_ff) begin
               bus_ff <= res_ff[par_ch_ff][RES_W-1 -: BUS_W];
               par_half_ff <= 1'b1;
            end else begin
               bus_ff <= {res_ff[par_ch_ff][LO_W-1:0], {(BUS_W - LO_W){1'b0}}};
               par_half_ff <= 1'b0;
               par_ch_ff <= par_ch_ff + 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Serial read path
   logic [CH_W-1:0] sch_ff;
   logic [SBIT_W-1:0] sbit_ff;
   logic [CH_W-1:0] nxt_sch;
   logic [SBIT_W-1:0] nxt_sbit;
   logic serial_out_a_ff;
   logic serial_out_b_ff;
   logic ser_start;
   logic ser_shift;

   assign ser_start = ser_mode_s & cs_fall;
   assign ser_shift = ser_mode_s & ~cs_n_s & rd_rise;

   always_comb begin
      nxt_sbit = sbit_ff - 1'b1;
      nxt_sch = sch_ff;
      if (sbit_ff == '0) begin
         nxt_sbit = MSB_IDX;
         nxt_sch = (sch_ff == SER_CH_END) ? sch_ff : sch_ff + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sch_ff <= FIRST_CH;
         sbit_ff <= MSB_IDX;
         serial_out_a_ff <= 1'b0;
         serial_out_b_ff <= 1'b0;
      end else if (clk_en) begin
         if (drst_rise) begin
            sch_ff <= FIRST_CH;
            sbit_ff <= MSB_IDX;
            serial_out_a_ff <= 1'b0;
            serial_out_b_ff <= 1'b0;
         end else if (ser_start) begin
            // MSB of first channel on both lines
            sch_ff <= FIRST_CH;
            sbit_ff <= MSB_IDX;
            serial_out_a_ff <= res_ff[{1'b0, FIRST_CH[GRP_W-1:0]}][MSB_IDX];
            serial_out_b_ff <= res_ff[{1'b1, FIRST_CH[GRP_W-1:0]}][MSB_IDX];
         end else if (ser_shift) begin
            sch_ff <= nxt_sch;
            sbit_ff <= nxt_sbit;
            // Past the fourth channel both lines idle low
            if (nxt_sch == SER_CH_END) begin
               serial_out_a_ff <= 1'b0;
               serial_out_b_ff <= 1'b0;
            end else begin
               serial_out_a_ff <= res_ff[{1'b0, nxt_sch[GRP_W-1:0]}][nxt_sbit];
               serial_out_b_ff <= res_ff[{1'b1, nxt_sch[GRP_W-1:0]}][nxt_sbit];
            end
         end
      end
   end

   // ==========================================================
   // First-channel indicator
   logic flag_ff;
   logic [SBIT_W-1:0] sfall_cnt_ff;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         flag_ff <= 1'b0;
         sfall_cnt_ff <= '0;
      end else if (clk_en) begin
         if (drst_rise) begin
            flag_ff <= 1'b0;
            sfall_cnt_ff <= '0;
         end else if (ser_mode_s) begin
            // high at select fall, low on 18th fall
            if (cs_fall) begin
               flag_ff <= 1'b1;
               sfall_cnt_ff <= '0;
            end else if (!cs_n_s && rd_fall && flag_ff) begin
               sfall_cnt_ff <= sfall_cnt_ff + 1'b1;
               if (sfall_cnt_ff + 1'b1 == SER_FLAG_END) begin
                  flag_ff <= 1'b0;
               end
            end
         end else if (par_read && !par_half_ff) begin
            // Set on the first channel, cleared on the third strobe
            if (par_ch_ff == FIRST_CH) begin
               flag_ff <= 1'b1;
            end else if (par_ch_ff == PAR_FLAG_CLR_CH) begin
               flag_ff <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // Pin drivers
   // parallel bus driven only with both strobes low
   always_comb begin
      parallel_result_bus_o = bus_ff;
      parallel_result_bus_oe = {BUS_W{~cs_n_s & ~rd_n_s}};
      if (ser_mode_s) begin
         // serial lines share two bus pins
         parallel_result_bus_o = '0;
         parallel_result_bus_oe = '0;
         parallel_result_bus_o[PIN_SER_A] = serial_out_a_ff;
         parallel_result_bus_o[PIN_SER_B] = serial_out_b_ff;
         parallel_result_bus_oe[PIN_SER_A] = ~cs_n_s;
         parallel_result_bus_oe[PIN_SER_B] = ~cs_n_s;
      end
   end

   assign first_channel_flag = flag_ff;
   assign first_channel_flag_oe = ~cs_n_s;
   assign busy = state_ff == ST_CONV;
   assign hold_group_a = hold_a_ff;
   assign hold_group_b = hold_b_ff;
   assign conv_start = conv_start_ff;
   assign conv_abort = conv_abort_ff;
   assign oversample_ratio = os_s;
   // range follows the pin at once
   assign input_range_wide = range_s;
   // range level picks the power-down mode
   assign standby_mode = pd_s & range_s;
   assign shutdown_mode = pd_s & ~range_s;
endmodule

// ===== core/ssa_pkg.sv
// Shared constants and types for the sampling converter host port
package ssa_pkg;
   // ==========================================================
   // Sizes
   localparam int RES_W = 18;
   localparam int NUM_CH = 8;
   localparam int CH_W = 3;
   localparam int BUS_W = 16;
   localparam int LO_W = RES_W - BUS_W;
   localparam int OS_W = 3;
   localparam int FIFO_DEPTH = 32;
   localparam int GRP_W = 2;
   localparam int SBIT_W = 5;
   // ==========================================================
   // Positions and counts
   localparam int PIN_SER_A = 7;
   localparam int PIN_SER_B = 8;
   localparam logic [SBIT_W-1:0] MSB_IDX = 5'h11;
   localparam logic [SBIT_W-1:0] SER_FLAG_END = 5'h12;
   localparam logic [CH_W-1:0] FIRST_CH = 3'h0;
   localparam logic [CH_W-1:0] PAR_FLAG_CLR_CH = 3'h1;
   localparam logic [CH_W-1:0] SER_CH_END = 3'h4;
   localparam logic [CH_W:0] LOAD_DONE = 4'h8;
   localparam logic [OS_W-1:0] OS_OFF = 3'h0;
   // ==========================================================
   // Conversion sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ARM = 3'b010,
      ST_CONV = 3'b100
   } ssa_state_t;
endpackage

// ===== core/ssa_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module ssa_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end else if (clk_en) begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;
endmodule

// ===== verif/ssa_core_model.sv
// Converter core stand-in answering a start with a burst of results
`timescale 1ns/1ps
module ssa_core_model
   import ssa_pkg::*;
(
   input wire logic clk_sys,
   input wire logic conv_start,
   input wire logic conv_abort,
   input wire logic result_ready,
   input wire logic [RES_W-1:0] base,
   input wire logic [6:0] n_words,
   output logic result_valid,
   output logic [RES_W-1:0] result_data
);
   // ==========
   // Burst
   initial begin
      result_valid = 1'b0;
      result_data = '0;
      forever begin
         do @(posedge clk_sys); while (!conv_start);
         for (int w = 0; w < 20 && !conv_abort; w++) begin
            @(posedge clk_sys);
         end
         for (int i = 0; i < n_words && !conv_abort; i++) begin
            result_valid <= 1'b1;
            result_data <= base + RES_W'(i);
            @(posedge clk_sys);
            while (!result_ready && !conv_abort) begin
               @(posedge clk_sys);
            end
         end
         result_valid <= 1'b0;
         // Stale data must not look valid
         result_data <= ~result_data;
      end
   end
endmodule

// ===== verif/ssa_host_port_checker.sv
// Pin-level assertions for the sampling converter host port
`timescale 1ns/1ps
module ssa_host_port_checker
   import ssa_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic interface_select,
   input wire logic power_down_request,
   input wire logic range_select,
   input wire logic convert_start_group_a,
   input wire logic chip_select_n,
   input wire logic [BUS_W-1:0] parallel_result_bus_oe,
   input wire logic first_channel_flag_oe,
   input wire logic busy,
   input wire logic hold_group_a,
   input wire logic hold_group_b,
   input wire logic conv_start,
   input wire logic conv_abort,
   input wire logic [OS_W-1:0] oversample_ratio,
   input wire logic input_range_wide,
   input wire logic standby_mode,
   input wire logic shutdown_mode
);
   // ==========
   // Properties
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   // Four cycles covers the two-flop pin sync
   property p_range;
      range_select [*4] |-> input_range_wide;
   endproperty
   a_range: assert property (p_range) else $error("range not wide");
   property p_standby;
      (power_down_request && range_select) [*4] |-> standby_mode && !shutdown_mode;
   endproperty
   a_standby: assert property (p_standby) else $error("standby wrong");
   property p_shutdown;
      (power_down_request && !range_select) [*4] |-> shutdown_mode && !standby_mode;
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("shutdown wrong");
   property p_par_oe;
      chip_select_n [*4] |-> parallel_result_bus_oe == 16'h0000;
   endproperty
   a_par_oe: assert property (p_par_oe) else $error("bus driven unselected");
   property p_ser_oe;
      interface_select [*4] |-> (parallel_result_bus_oe & 16'hFE7F) == 16'h0000;
   endproperty
   a_ser_oe: assert property (p_ser_oe) else $error("serial drives other pins");
   property p_hold;
      $rose(hold_group_a) && oversample_ratio == 3'h0 |-> $past(convert_start_group_a, 2);
   endproperty
   a_hold: assert property (p_hold) else $error("hold without start");
   property p_start;
      conv_start |-> hold_group_a && hold_group_b ##1 busy && !conv_start;
   endproperty
   a_start: assert property (p_start) else $error("start pulse wrong");
   property p_busy;
      $rose(busy) |-> hold_group_a && hold_group_b;
   endproperty
   a_busy: assert property (p_busy) else $error("busy before both holds");
   property p_abort;
      conv_abort |-> ##[0:2] !busy;
   endproperty
   a_abort: assert property (p_abort) else $error("abort left busy");
   property p_flag_oe;
      chip_select_n [*4] |-> !first_channel_flag_oe;
   endproperty
   a_flag_oe: assert property (p_flag_oe) else $error("flag driven unselected");
endmodule

bind ssa_host_port ssa_host_port_checker chk (.*);

// ===== verif/tb.sv
// Self-checking bench for the sampling converter host port
`timescale 1ns/1ps
module tb;
   import ssa_pkg::*;
   logic clk_sys, rstn, interface_select, power_down_request, range_select;
   logic convert_start_group_a, convert_start_group_b, device_reset, chip_select_n;
   logic read_strobe_n, first_channel_flag, first_channel_flag_oe, busy, conv_start;
   logic hold_group_a, hold_group_b, conv_abort, input_range_wide, standby_mode;
   logic shutdown_mode, result_valid, result_ready;
   logic [OS_W-1:0] oversample_ratio_sel, oversample_ratio;
   logic [BUS_W-1:0] bus_o, bus_oe;
   logic [RES_W-1:0] result_data, base;
   logic [6:0] n_words;
   int failures, n_checks, n_push, cycles;
   ssa_host_port uut (.clk_sys(clk_sys), .rstn(rstn), .clk_en(1'b1),
      .oversample_ratio_sel(oversample_ratio_sel), .interface_select(interface_select),
      .power_down_request(power_down_request), .range_select(range_select),
      .convert_start_group_a(convert_start_group_a), .device_reset(device_reset),
      .convert_start_group_b(convert_start_group_b), .chip_select_n(chip_select_n),
      .read_strobe_n(read_strobe_n), .parallel_result_bus_o(bus_o),
      .parallel_result_bus_oe(bus_oe), .first_channel_flag(first_channel_flag),
      .first_channel_flag_oe(first_channel_flag_oe), .busy(busy), .conv_start(conv_start),
      .hold_group_a(hold_group_a), .hold_group_b(hold_group_b), .conv_abort(conv_abort),
      .oversample_ratio(oversample_ratio), .input_range_wide(input_range_wide),
      .standby_mode(standby_mode), .shutdown_mode(shutdown_mode),
      .result_valid(result_valid), .result_ready(result_ready), .result_data(result_data));
   ssa_core_model core (.clk_sys(clk_sys), .conv_start(conv_start), .conv_abort(conv_abort),
      .result_ready(result_ready), .base(base), .n_words(n_words),
      .result_valid(result_valid), .result_data(result_data));
   // ==========
   // Clock, watchdog
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (result_valid && result_ready) n_push++;
      if (cycles == 30000) begin
         failures++;
         report_and_stop();
      end
   end
   // ==========
   // Helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic check(input string what, input logic [RES_W-1:0] seen,
      input logic [RES_W-1:0] want);
      n_checks++;
      if (seen !== want) begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   function automatic logic [RES_W-1:0] exp_res(input int ch);
      return base + RES_W'(ch);
   endfunction
   // separate starts only with oversampling off
   task automatic start();
      int gap;
      gap = 6 + $urandom % 4;
      convert_start_group_a <= 1'b1;
      cyc(5);
      check("hold_a", hold_group_a, 1'b1);
      check("hold_b", hold_group_b, 1'b0);
      cyc(gap - 5);
      convert_start_group_b <= 1'b1;
      cyc(6);
      check("busy", busy, 1'b1);
      convert_start_group_a <= 1'b0;
      cyc(2);
      convert_start_group_a <= 1'b1;
   endtask
   task automatic finish_conv();
      int n;
      n = 0;
      while (busy === 1'b1 && n < 400) begin
         cyc(1);
         n++;
      end
      check("busy_done", busy, 1'b0);
      check("hold_ignored", hold_group_a, 1'b0);
      convert_start_group_a <= 1'b0;
      convert_start_group_b <= 1'b0;
      cyc(4);
   endtask
   task automatic read_par(input int nch, input logic zero);
      logic [RES_W-1:0] e;
      chip_select_n <= 1'b0;
      for (int i = 0; i < nch; i++) begin
         e = zero ? '0 : exp_res(i);
         read_strobe_n <= 1'b0;
         cyc(4);
         check("bus_hi", bus_o, e[17:2]);
         check("bus_oe", bus_oe, 16'hFFFF);
         check("flag_par", first_channel_flag, i == 0);
         read_strobe_n <= 1'b1;
         cyc(4);
         check("bus_off", bus_oe, 16'h0000);
         read_strobe_n <= 1'b0;
         cyc(4);
         check("bus_lo", bus_o, {e[1:0], 14'h0000});
         read_strobe_n <= 1'b1;
         cyc(4);
      end
      chip_select_n <= 1'b1;
      cyc(4);
   endtask
   // select held low for the frame
   task automatic read_ser();
      logic [RES_W-1:0] ea, eb;
      chip_select_n <= 1'b0;
      cyc(5);
      check("ser_oe", bus_oe, 16'h0180);
      for (int k = 0; k < 72; k++) begin
         ea = exp_res(k / 18);
         eb = exp_res(k / 18 + 4);
         check("line_a", bus_o[PIN_SER_A], ea[17 - k % 18]);
         check("line_b", bus_o[PIN_SER_B], eb[17 - k % 18]);
         read_strobe_n <= 1'b0;
         cyc(4);
         check("flag_ser", first_channel_flag, k < 17);
         read_strobe_n <= 1'b1;
         cyc(4);
      end
      chip_select_n <= 1'b1;
      cyc(4);
   endtask
   // ==========
   // Main sequence
   initial begin
      rstn = 1'b0;
      {interface_select, power_down_request, range_select, device_reset} = 4'h0;
      {convert_start_group_a, convert_start_group_b} = 2'h0;
      {chip_select_n, read_strobe_n} = 2'h3;
      oversample_ratio_sel = 3'h0;
      base = '0;
      n_words = 7'h08;
      {failures, n_checks, n_push, cycles} = '0;
      void'($urandom(23));
      cyc(6);
      rstn <= 1'b1;
      cyc(2);
      device_reset <= 1'b1;
      cyc(4);
      device_reset <= 1'b0;
      cyc(4);
      for (int m = 0; m < 4; m++) begin
         power_down_request <= m[1];
         range_select <= m[0];
         oversample_ratio_sel <= 3'($urandom);
         cyc(5);
         check("range", input_range_wide, m[0]);
         check("standby", standby_mode, m[1] & m[0]);
         check("shutdown", shutdown_mode, m[1] & ~m[0]);
         check("os", oversample_ratio, oversample_ratio_sel);
      end
      power_down_request <= 1'b0;
      oversample_ratio_sel <= 3'h0;
      base <= 18'($urandom);
      $display("config test done");
      cyc(4);
      start();
      finish_conv();
      read_par(8, 1'b0);
      $display("parallel read test done");
      base <= 18'($urandom);
      start();
      finish_conv();
      interface_select <= 1'b1;
      cyc(4);
      read_ser();
      interface_select <= 1'b0;
      $display("serial read test done");
      n_words <= 7'h28;
      chip_select_n <= 1'b0;
      cyc(4);
      start();
      cyc(100);
      check("ready_full", result_ready, 1'b0);
      check("pushed", 18'(n_push), 18'(16 + FIFO_DEPTH));
      // pulse wide enough to be seen
      device_reset <= 1'b1;
      cyc(4);
      device_reset <= 1'b0;
      convert_start_group_a <= 1'b0;
      convert_start_group_b <= 1'b0;
      cyc(6);
      check("abort_busy", busy, 1'b0);
      check("abort_hold", hold_group_a, 1'b0);
      read_par(1, 1'b1);
      // oversampling on: one edge holds both
      n_words <= 7'h08;
      oversample_ratio_sel <= 3'h1 + 3'($urandom % 7);
      cyc(4);
      convert_start_group_a <= 1'b1;
      cyc(6);
      check("hold_b_os", hold_group_b, 1'b1);
      finish_conv();
      {convert_start_group_a, convert_start_group_b} <= 2'h3;
      cyc(6);
      check("busy_tied", busy, 1'b1);
      finish_conv();
      $display("fill and reset test done");
      report_and_stop();
   end
endmodule
